// >>> inc/rsso_pkg.sv
package rsso_pkg;

  // ---------------------------------------------------------------
  // register port layout
  // ---------------------------------------------------------------
  localparam int         REG_W         = 8;
  localparam int         IDX_W         = 2;
  localparam logic [1:0] IDX_STATUS    = 2'h0;
  localparam logic [1:0] IDX_FORCE     = 2'h1;
  localparam logic [1:0] IDX_OPT1      = 2'h2;

  // ---------------------------------------------------------------
  // reset-cause field positions
  // ---------------------------------------------------------------
  localparam int         ST_POR_BIT    = 7;
  localparam int         ST_PIN_BIT    = 6;
  localparam int         ST_WDOG_BIT   = 5;
  localparam int         ST_ILLEGAL_OPCODE_FLAG_BIT   = 4;
  localparam int         ST_CLKGEN_BIT = 2;
  localparam int         ST_LOWV_BIT   = 1;
  localparam logic [7:0] ST_POR_VALUE  = 8'h82;
  localparam logic [7:0] ST_ZERO       = 8'h00;

  // ---------------------------------------------------------------
  // force-reset and options field positions
  // ---------------------------------------------------------------
  localparam int         FORCE_BIT     = 0;
  localparam int         OPT_WDOG_EN   = 7;
  localparam int         OPT_WDOG_TO   = 6;
  localparam int         OPT_STOP      = 5;
  localparam int         OPT_DBGPIN    = 1;
  localparam int         OPT_RSTPIN    = 0;

  // ---------------------------------------------------------------
  // option reset values
  // ---------------------------------------------------------------
  localparam logic       RST_WDOG_EN   = 1'b1;
  localparam logic       RST_WDOG_TO   = 1'b1;
  localparam logic       RST_STOP      = 1'b0;
  localparam logic       RST_DBGPIN    = 1'b1;
  localparam logic       RST_RSTPIN    = 1'b0;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CAPT = 2'b01,
    ST_RUN  = 2'b10
  } rsso_state_t;

endpackage : rsso_pkg

// >>> core/rsso_once.sv
`timescale 1ns/100ps
module rsso_once
  import rsso_pkg::*;
(
  // clock and reset
  input  wire logic CORE_CLK_IN,
  input  wire logic RSTN_IN,
  // write side
  input  wire logic wr_en_in,
  input  wire logic [7:0] wdata_in,
  // held options
  output logic      wdog_en_out,
  output logic      wdog_long_out,
  output logic      stop_permit_out,
  output logic      dbg_pin_en_out,
  output logic      written_out
);

  logic accept;

  assign accept = wr_en_in & ~written_out;

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      wdog_en_out     <= RST_WDOG_EN;
      wdog_long_out   <= RST_WDOG_TO;
      stop_permit_out <= RST_STOP;
      dbg_pin_en_out  <= RST_DBGPIN;
      written_out     <= 1'b0;
    end else if (accept) begin
      wdog_en_out     <= wdata_in[OPT_WDOG_EN];
      wdog_long_out   <= wdata_in[OPT_WDOG_TO];
      stop_permit_out <= wdata_in[OPT_STOP];
      dbg_pin_en_out  <= wdata_in[OPT_DBGPIN];
      written_out     <= 1'b1;
    end
  end

  property p_once_locked;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (written_out && wr_en_in) |=>
      ($stable(wdog_en_out) && $stable(wdog_long_out) && $stable(stop_permit_out) && $stable(dbg_pin_en_out));
  endproperty
  a_once_locked: assert property (p_once_locked) else $error("options changed after first write");

  property p_once_first;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (!written_out && wr_en_in) |=> (written_out && stop_permit_out == $past(wdata_in[OPT_STOP]));
  endproperty
  a_once_first: assert property (p_once_first) else $error("first options write not taken");

endmodule : rsso_once

// >>> core/rsso_core.sv
`timescale 1ns/100ps
module rsso_core
  import rsso_pkg::*;
(
  // clock and reset
  input  wire logic             CORE_CLK_IN,
  input  wire logic             RSTN_IN,
  // register port
  input  wire logic [IDX_W-1:0] REG_IDX_IN,
  input  wire logic             REG_WR_IN,
  input  wire logic             REG_RD_IN,
  input  wire logic [REG_W-1:0] REG_WDATA_IN,
  input  wire logic             REG_BDM_IN,
  output logic      [REG_W-1:0] REG_RDATA_OUT,
  // cause levels held by the reset controller through reset
  input  wire logic             CAUSE_POR_IN,
  input  wire logic             CAUSE_LVR_IN,
  input  wire logic             CAUSE_PIN_IN,
  input  wire logic             CAUSE_WDOG_IN,
  input  wire logic             CAUSE_ILLEGAL_OPCODE_FLAG_IN,
  input  wire logic             CAUSE_CLKGEN_IN,
  input  wire logic             CAUSE_FORCE_IN,
  // reset sources
  input  wire logic             WDOG_TIMEOUT_IN,
  input  wire logic             STOP_EXEC_IN,
  input  wire logic             BACKGROUND_INSTRUCTION_EXEC_IN,
  input  wire logic             ILLEGAL_OP_IN,
  input  wire logic             BG_MODE_EN_IN,
  input  wire logic             LOWV_TRIP_IN,
  input  wire logic             LOWV_DETECT_EN_IN,
  input  wire logic             LOWV_RESET_EN_IN,
  input  wire logic             LOWV_STOP_EN_IN,
  input  wire logic             STOP_MODE_IN,
  // reset requests
  output logic                  WDOG_RST_REQ_OUT,
  output logic                  ILLEGAL_OPCODE_FLAG_RST_REQ_OUT,
  output logic                  LOWV_RST_REQ_OUT,
  output logic                  FORCE_RST_REQ_OUT,
  // watchdog control
  output logic                  WDOG_CLEAR_OUT,
  output logic                  WDOG_ENABLE_OUT,
  output logic                  WDOG_LONG_OUT,
  // mode and pin control
  output logic                  STOP_PERMIT_OUT,
  output logic                  DEBUG_PIN_EN_OUT,
  output logic                  RESET_PIN_EN_OUT,
  output logic                  OPT_WRITTEN_OUT
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rsso_state_t state_r;
  logic [7:0]  status_r;
  logic [7:0]  status_nxt;
  logic        rstpin_r;
  logic        rstpin_nxt;
  logic [7:0]  rdata_nxt;

  wire run     = (state_r == ST_RUN);
  wire capt    = (state_r == ST_CAPT);
  wire wr_stat = run & REG_WR_IN & (REG_IDX_IN == IDX_STATUS);
  wire wr_frc  = run & REG_WR_IN & (REG_IDX_IN == IDX_FORCE);
  wire wr_opt  = run & REG_WR_IN & (REG_IDX_IN == IDX_OPT1);
  wire rd_any  = run & REG_RD_IN;

  // ---------------------------------------------------------------
  // reset-cause capture
  // ---------------------------------------------------------------
  // flags are sampled on the first edge after release: an async
  // reset can only load constants, and lvr must keep the old por bit
  wire [7:0] other_cause = (8'(CAUSE_PIN_IN)    << ST_PIN_BIT)
                         | (8'(CAUSE_WDOG_IN)   << ST_WDOG_BIT)
                         | (8'(CAUSE_ILLEGAL_OPCODE_FLAG_IN)   << ST_ILLEGAL_OPCODE_FLAG_BIT)
                         | (8'(CAUSE_CLKGEN_IN) << ST_CLKGEN_BIT);
  wire [7:0] lvr_cause   = (8'(status_r[ST_POR_BIT]) << ST_POR_BIT)
                         | (8'h01 << ST_LOWV_BIT);

  always_comb begin
    if (!capt) begin
      status_nxt = status_r;
    end else if (CAUSE_FORCE_IN) begin
      status_nxt = ST_ZERO;
    end else if (CAUSE_POR_IN) begin
      status_nxt = ST_POR_VALUE;
    end else if (CAUSE_LVR_IN) begin
      status_nxt = lvr_cause;
    end else begin
      status_nxt = other_cause;
    end
  end

  // only power-on drops the reset pin back to its port function
  always_comb begin
    if (capt && CAUSE_POR_IN) begin
      rstpin_nxt = RST_RSTPIN;
    end else if (wr_opt && !OPT_WRITTEN_OUT) begin
      rstpin_nxt = REG_WDATA_IN[OPT_RSTPIN];
    end else begin
      rstpin_nxt = rstpin_r;
    end
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_r <= ST_CAPT;
    end else begin
      unique case (state_r)
        ST_CAPT: begin
          state_r <= ST_RUN;
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_CAPT;
        end
      endcase
    end
  end

  // not reset on purpose: these must survive a non power-on reset
  always_ff @(posedge CORE_CLK_IN) begin
    status_r <= status_nxt;
    rstpin_r <= rstpin_nxt;
  end

  // ---------------------------------------------------------------
  // write-once options
  // ---------------------------------------------------------------
  rsso_once u_once (
    .CORE_CLK_IN     (CORE_CLK_IN),
    .RSTN_IN         (RSTN_IN),
    .wr_en_in        (wr_opt),
    .wdata_in        (REG_WDATA_IN),
    .wdog_en_out     (WDOG_ENABLE_OUT),
    .wdog_long_out   (WDOG_LONG_OUT),
    .stop_permit_out (STOP_PERMIT_OUT),
    .dbg_pin_en_out  (DEBUG_PIN_EN_OUT),
    .written_out     (OPT_WRITTEN_OUT)
  );

  assign RESET_PIN_EN_OUT = rstpin_r;

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  wire illegal_opcode_flag_hit  = (STOP_EXEC_IN & ~STOP_PERMIT_OUT)
                 | (BACKGROUND_INSTRUCTION_EXEC_IN & ~BG_MODE_EN_IN)
                 | ILLEGAL_OP_IN;
  wire wdog_hit  = WDOG_TIMEOUT_IN & WDOG_ENABLE_OUT;
  wire lowv_live = LOWV_DETECT_EN_IN & (~STOP_MODE_IN | LOWV_STOP_EN_IN);
  wire lowv_hit  = LOWV_TRIP_IN & lowv_live & LOWV_RESET_EN_IN;
  // user-program writes never reach the force request
  wire force_hit = wr_frc & REG_BDM_IN & REG_WDATA_IN[FORCE_BIT];

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      WDOG_RST_REQ_OUT  <= 1'b0;
      ILLEGAL_OPCODE_FLAG_RST_REQ_OUT  <= 1'b0;
      LOWV_RST_REQ_OUT  <= 1'b0;
      FORCE_RST_REQ_OUT <= 1'b0;
      WDOG_CLEAR_OUT    <= 1'b0;
    end else begin
      WDOG_RST_REQ_OUT  <= run & wdog_hit;
      ILLEGAL_OPCODE_FLAG_RST_REQ_OUT  <= run & illegal_opcode_flag_hit;
      LOWV_RST_REQ_OUT  <= run & lowv_hit;
      FORCE_RST_REQ_OUT <= force_hit;
      WDOG_CLEAR_OUT    <= wr_stat;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  function automatic logic [7:0] read_mux(input logic [1:0] idx, input logic [7:0] st, input logic [7:0] opt);
    logic [7:0] v;
    v = ST_ZERO;
    unique case (idx)
      IDX_STATUS: v = st;
      IDX_OPT1:   v = opt;
      default:    v = ST_ZERO;
    endcase
    return v;
  endfunction : read_mux

  wire [7:0] opt_view = (8'(WDOG_ENABLE_OUT)  << OPT_WDOG_EN)
                      | (8'(WDOG_LONG_OUT)    << OPT_WDOG_TO)
                      | (8'(STOP_PERMIT_OUT)  << OPT_STOP)
                      | (8'(DEBUG_PIN_EN_OUT) << OPT_DBGPIN)
                      | (8'(rstpin_r)         << OPT_RSTPIN);
  wire [7:0] st_view  = status_r & (ST_POR_VALUE | other_cause_mask());

  function automatic logic [7:0] other_cause_mask();
    return (8'h01 << ST_PIN_BIT) | (8'h01 << ST_WDOG_BIT)
         | (8'h01 << ST_ILLEGAL_OPCODE_FLAG_BIT) | (8'h01 << ST_CLKGEN_BIT);
  endfunction : other_cause_mask

  assign rdata_nxt = rd_any ? read_mux(REG_IDX_IN, st_view, opt_view) : REG_RDATA_OUT;

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      REG_RDATA_OUT <= ST_ZERO;
    end else begin
      REG_RDATA_OUT <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_st_zero_bits;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rd_any && REG_IDX_IN == IDX_STATUS) |=> (REG_RDATA_OUT[3] == 1'b0 && REG_RDATA_OUT[0] == 1'b0);
  endproperty
  a_st_zero_bits: assert property (p_st_zero_bits) else $error("cause bits 3/0 not zero");

  property p_force_clear;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (capt && CAUSE_FORCE_IN) |=> (status_r == ST_ZERO);
  endproperty
  a_force_clear: assert property (p_force_clear) else $error("flags set after forced reset");

  property p_stat_write;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    wr_stat |=> (WDOG_CLEAR_OUT && $stable(status_r));
  endproperty
  a_stat_write: assert property (p_stat_write) else $error("status write misbehaved");

  property p_por_value;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (capt && CAUSE_POR_IN && !CAUSE_FORCE_IN) |=> (status_r == ST_POR_VALUE && !rstpin_r);
  endproperty
  a_por_value: assert property (p_por_value) else $error("power-on cause wrong");

  property p_lvr_value;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (capt && CAUSE_LVR_IN && !CAUSE_POR_IN && !CAUSE_FORCE_IN) |=>
      (status_r[ST_POR_BIT] == $past(status_r[ST_POR_BIT]) && status_r[6:1] == 6'h01);
  endproperty
  a_lvr_value: assert property (p_lvr_value) else $error("low-voltage cause wrong");

  property p_illegal_opcode_flag_stop;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (run && STOP_EXEC_IN && !STOP_PERMIT_OUT) |=> ILLEGAL_OPCODE_FLAG_RST_REQ_OUT;
  endproperty
  a_illegal_opcode_flag_stop: assert property (p_illegal_opcode_flag_stop) else $error("illegal stop not reset");

  property p_wdog_block;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    !WDOG_ENABLE_OUT |=> !WDOG_RST_REQ_OUT;
  endproperty
  a_wdog_block: assert property (p_wdog_block) else $error("disabled watchdog reset");

  property p_lowv_gate;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (!LOWV_RESET_EN_IN || !LOWV_DETECT_EN_IN || (STOP_MODE_IN && !LOWV_STOP_EN_IN)) |=> !LOWV_RST_REQ_OUT;
  endproperty
  a_lowv_gate: assert property (p_lowv_gate) else $error("gated low-voltage reset");

  property p_force_user;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (REG_WR_IN && REG_IDX_IN == IDX_FORCE && !REG_BDM_IN) |=> !FORCE_RST_REQ_OUT;
  endproperty
  a_force_user: assert property (p_force_user) else $error("user force write honoured");

  property p_force_read;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rd_any && REG_IDX_IN == IDX_FORCE) |=> (REG_RDATA_OUT == ST_ZERO);
  endproperty
  a_force_read: assert property (p_force_read) else $error("force register read nonzero");

  property p_opt_zero;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (rd_any && REG_IDX_IN == IDX_OPT1) |=> (REG_RDATA_OUT[3:2] == 2'h0);
  endproperty
  a_opt_zero: assert property (p_opt_zero) else $error("options bits 3/2 nonzero");

  property p_other_clear;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (capt && !CAUSE_FORCE_IN && !CAUSE_POR_IN && !CAUSE_LVR_IN) |=>
      (!status_r[ST_POR_BIT] && !status_r[ST_LOWV_BIT] && status_r[ST_WDOG_BIT] == $past(CAUSE_WDOG_IN));
  endproperty
  a_other_clear: assert property (p_other_clear) else $error("other-reset cause wrong");

  property p_pin_flag;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (capt && CAUSE_PIN_IN && !CAUSE_FORCE_IN && !CAUSE_POR_IN && !CAUSE_LVR_IN) |=> status_r[ST_PIN_BIT];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin cause not flagged");

  property p_illegal_opcode_flag_background_instruction;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (run && BACKGROUND_INSTRUCTION_EXEC_IN && !BG_MODE_EN_IN) |=> ILLEGAL_OPCODE_FLAG_RST_REQ_OUT;
  endproperty
  a_illegal_opcode_flag_background_instruction: assert property (p_illegal_opcode_flag_background_instruction) else $error("illegal background not reset");

  property p_wdog_fire;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (run && WDOG_TIMEOUT_IN && WDOG_ENABLE_OUT) |=> WDOG_RST_REQ_OUT;
  endproperty
  a_wdog_fire: assert property (p_wdog_fire) else $error("enabled watchdog did not reset");

  property p_lowv_fire;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (run && LOWV_TRIP_IN && LOWV_DETECT_EN_IN && LOWV_RESET_EN_IN && (!STOP_MODE_IN || LOWV_STOP_EN_IN)) |=>
      LOWV_RST_REQ_OUT;
  endproperty
  a_lowv_fire: assert property (p_lowv_fire) else $error("low-voltage trip did not reset");

  property p_force_bdm;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (run && REG_WR_IN && REG_IDX_IN == IDX_FORCE && REG_BDM_IN && REG_WDATA_IN[FORCE_BIT]) |=>
      FORCE_RST_REQ_OUT;
  endproperty
  a_force_bdm: assert property (p_force_bdm) else $error("debug force write not honoured");

  property p_opt_reset;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    capt |-> (DEBUG_PIN_EN_OUT && WDOG_ENABLE_OUT && !STOP_PERMIT_OUT && !OPT_WRITTEN_OUT);
  endproperty
  a_opt_reset: assert property (p_opt_reset) else $error("options not at reset values");

  property p_rstpin_keep;
    @(posedge CORE_CLK_IN) disable iff (!RSTN_IN)
    (capt && !CAUSE_POR_IN) |=> $stable(rstpin_r);
  endproperty
  a_rstpin_keep: assert property (p_rstpin_keep) else $error("reset pin select lost");

endmodule : rsso_core

// >>> dv/rsso_rstctl_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// reset controller: turns requests into a held system reset
// ---------------------------------------------------------------
module rsso_rstctl_model (
  // clock
  input  wire logic       clk_in,
  // reset sources
  input  wire logic       por_in,
  input  wire logic       pin_in,
  input  wire logic       clkgen_in,
  input  wire logic       lowv_req_in,
  input  wire logic       wdog_req_in,
  input  wire logic       illegal_opcode_flag_req_in,
  input  wire logic       force_req_in,
  // reset and causes {force,clkgen,illegal_opcode_flag,wdog,pin,lvr,por}
  output logic            rstn_out,
  output logic      [6:0] cause_out
);
  logic [2:0] cnt_r   = 3'h7;
  logic       rstn_r  = 1'b0;
  logic [6:0] cause_r = 7'h01;
  logic [6:0] req;

  // pin_in high stands for the reset pin held at its low level
  assign req       = {force_req_in, clkgen_in, illegal_opcode_flag_req_in, wdog_req_in, pin_in, lowv_req_in, por_in};
  assign rstn_out  = rstn_r;
  assign cause_out = cause_r;

  // causes held three edges past release, so capture never sees them drop
  always_ff @(posedge clk_in) begin
    if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
      if (cnt_r == 3'h4) rstn_r <= 1'b1;
      if (cnt_r == 3'h1) cause_r <= 7'h00;
    end else if (|req) begin
      cause_r <= req;
      rstn_r  <= 1'b0;
      cnt_r   <= 3'h7;
    end
  end
endmodule : rsso_rstctl_model

// >>> dv/reset_status_and_system_options_tb_top.sv
`timescale 1ns/100ps
module reset_status_and_system_options_tb_top;
  import rsso_pkg::*;
  logic clk, rstn, wr, rd, bdm, wdog_to, stop_ex, background_instruction_ex, ill_op, bg_en;
  logic trip, det, rse, stp, stop_mode, e_por, e_pin, e_clk;
  logic wreq, ireq, lreq, freq, clr, wen, wlong, stop_p, dbg, rpin, written;
  logic [1:0] idx;
  logic [7:0] wdata, rdata;
  logic [6:0] cause;
  int errors = 0;
  int total_checks = 0;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  rsso_rstctl_model RCM (.clk_in(clk), .por_in(e_por), .pin_in(e_pin), .clkgen_in(e_clk), .lowv_req_in(lreq),
    .wdog_req_in(wreq), .illegal_opcode_flag_req_in(ireq), .force_req_in(freq), .rstn_out(rstn), .cause_out(cause));

  rsso_core DUT (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .REG_IDX_IN(idx), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_WDATA_IN(wdata), .REG_BDM_IN(bdm), .REG_RDATA_OUT(rdata), .CAUSE_POR_IN(cause[0]),
    .CAUSE_LVR_IN(cause[1]), .CAUSE_PIN_IN(cause[2]), .CAUSE_WDOG_IN(cause[3]), .CAUSE_ILLEGAL_OPCODE_FLAG_IN(cause[4]),
    .CAUSE_CLKGEN_IN(cause[5]), .CAUSE_FORCE_IN(cause[6]), .WDOG_TIMEOUT_IN(wdog_to), .STOP_EXEC_IN(stop_ex),
    .BACKGROUND_INSTRUCTION_EXEC_IN(background_instruction_ex), .ILLEGAL_OP_IN(ill_op), .BG_MODE_EN_IN(bg_en), .LOWV_TRIP_IN(trip),
    .LOWV_DETECT_EN_IN(det), .LOWV_RESET_EN_IN(rse), .LOWV_STOP_EN_IN(stp), .STOP_MODE_IN(stop_mode),
    .WDOG_RST_REQ_OUT(wreq), .ILLEGAL_OPCODE_FLAG_RST_REQ_OUT(ireq), .LOWV_RST_REQ_OUT(lreq), .FORCE_RST_REQ_OUT(freq),
    .WDOG_CLEAR_OUT(clr), .WDOG_ENABLE_OUT(wen), .WDOG_LONG_OUT(wlong), .STOP_PERMIT_OUT(stop_p),
    .DEBUG_PIN_EN_OUT(dbg), .RESET_PIN_EN_OUT(rpin), .OPT_WRITTEN_OUT(written));

  // ---------------------------------------------------------------
  // compare, report and bus tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  task automatic wrr(input logic [1:0] i, input logic [7:0] d, input logic b);
    @(posedge clk); #2;
    idx = i; wdata = d; bdm = b; wr = 1'b1;
    @(posedge clk); #2;
    wr = 1'b0; bdm = 1'b0;
  endtask : wrr

  task automatic rdc(input logic [1:0] i, input logic [7:0] exp);
    @(posedge clk); #2;
    idx = i; rd = 1'b1;
    @(posedge clk); #2;
    rd = 1'b0;
    chk8(rdata, exp, "read data");
  endtask : rdc

  // waits out a reset in flight, then checks the captured causes
  task automatic rst_done(input logic [7:0] exp);
    int n;
    n = 0;
    while (rstn !== 1'b0 && n < 10) begin @(posedge clk); n++; end
    if (rstn !== 1'b0) n = 20;
    while (rstn !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    if (n >= 20) begin
      errors++;
      $display("mismatch at %0t: reset never completed", $time);
      results();
    end
    @(posedge clk);
    rdc(IDX_STATUS, exp);
  endtask : rst_done

  // one-cycle source event; sel 0 timeout 1 stop 2 background 3 illegal 4 low voltage
  task automatic pulse(input int sel, input logic exp);
    logic got;
    @(posedge clk); #2;
    case (sel)
      0: wdog_to = 1'b1;
      1: stop_ex = 1'b1;
      2: background_instruction_ex = 1'b1;
      3: ill_op = 1'b1;
      default: trip = 1'b1;
    endcase
    @(posedge clk); #2;
    got = (sel == 0) ? wreq : (sel == 4) ? lreq : ireq;
    chk1(got, exp, "reset request");
    {wdog_to, stop_ex, background_instruction_ex, ill_op, trip} = 5'h00;
  endtask : pulse

  task automatic opts(input logic [7:0] exp, input logic wtn);
    rdc(IDX_OPT1, exp);
    chk8({wen, wlong, stop_p, dbg, rpin, written}, {exp[7:5], exp[1:0], wtn}, "option outputs");
  endtask : opts

  task automatic ext(input logic [2:0] m, input logic [7:0] exp);
    @(posedge clk); #2;
    {e_clk, e_pin, e_por} = m;
    @(posedge clk); #2;
    {e_clk, e_pin, e_por} = 3'h0;
    rst_done(exp);
  endtask : ext

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_por();
    rst_done(8'h82);
    opts(8'hC2, 1'b0);
    rdc(IDX_FORCE, 8'h00);
    rdc(2'h3, 8'h00);
    wrr(IDX_STATUS, 8'hFF, 1'b0);
    chk1(clr, 1'b1, "watchdog restart");
    rdc(IDX_STATUS, 8'h82);
  endtask : t_por

  task automatic t_lowv();
    {det, rse} = 2'b01;
    pulse(4, 1'b0);
    {det, rse} = 2'b10;
    pulse(4, 1'b0);
    {det, rse, stop_mode, stp} = 4'b1110;
    pulse(4, 1'b0);
    stp = 1'b1;
    pulse(4, 1'b1);
    stop_mode = 1'b0;
    rst_done(8'h82);
  endtask : t_lowv

  task automatic t_sources();
    ext(3'h2, 8'h40);
    ext(3'h4, 8'h04);
    pulse(0, 1'b1);
    rst_done(8'h20);
    for (int s = 1; s < 4; s++) begin
      pulse(s, 1'b1);
      rst_done(8'h10);
    end
    pulse(4, 1'b1);
    rst_done(8'h02);
  endtask : t_sources

  task automatic t_once();
    wrr(IDX_OPT1, 8'h2D, 1'b0);
    chk1(clr, 1'b0, "watchdog restart");
    opts(8'h21, 1'b1);
    wrr(IDX_OPT1, 8'hC2, 1'b0);
    opts(8'h21, 1'b1);
    pulse(0, 1'b0);
    pulse(1, 1'b0);
    bg_en = 1'b1;
    pulse(2, 1'b0);
  endtask : t_once

  task automatic t_force();
    wrr(IDX_FORCE, 8'h01, 1'b0);
    chk1(freq, 1'b0, "force request");
    wrr(IDX_FORCE, 8'hFE, 1'b1);
    chk1(freq, 1'b0, "force request");
    wrr(IDX_FORCE, 8'h01, 1'b1);
    chk1(freq, 1'b1, "force request");
    rst_done(8'h00);
    opts(8'hC3, 1'b0);
  endtask : t_force

  // ---------------------------------------------------------------
  // main sequence; reset is held by the controller model at start
  // ---------------------------------------------------------------
  initial begin
    {idx, wr, rd, bdm, wdata} = 13'h0000;
    {wdog_to, stop_ex, background_instruction_ex, ill_op, bg_en, trip, det, rse, stp, stop_mode} = 10'h000;
    {e_por, e_pin, e_clk} = 3'h0;
    t_por();
    t_lowv();
    t_once();
    t_force();
    bg_en = 1'b0;
    {det, rse, stp} = 3'b110;
    t_sources();
    ext(3'h1, 8'h82);
    opts(8'hC2, 1'b0);
    results();
  end
endmodule : reset_status_and_system_options_tb_top
